// ---- logic/ctls_cfg.svh ----
`ifndef CTLS_CFG_SVH
`define CTLS_CFG_SVH
// ---------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------
`define CTLS_A_CTRL 8'h00
`define CTLS_A_STAT 8'h04
`define CTLS_A_VIOL 8'h08
`define CTLS_A_MAXLEN 8'h0c
`define CTLS_A_DELAY 8'h10
// ---------------------------------------------
// Field positions and reset values
// ---------------------------------------------
`define CTLS_CTRL_EN 0
`define CTLS_CTRL_FRAMED 1
`define CTLS_CTRL_FEN 2
`define CTLS_CTRL_RST 3'h1
`define CTLS_MAXLEN_RST 8'h1d
`define CTLS_V_RXLATE 0
`define CTLS_V_TXLATE 1
`define CTLS_V_OVF 2
`define CTLS_V_DROP 3
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define CTLS_CLK_MHZ 10
`define CTLS_BASE_US 500
`define CTLS_BYTE_US 11
`define CTLS_BASE_CYC (`CTLS_BASE_US * `CTLS_CLK_MHZ)
`define CTLS_BYTE_CYC (`CTLS_BYTE_US * `CTLS_CLK_MHZ)
`endif

// ---- logic/ctls_pkg.sv ----
package ctls_pkg;
    typedef enum logic [3:0] {
        ADM_DATA = 4'h0,
        ADM_PROTO_A = 4'h1,
        ADM_PROTO_F = 4'h2,
        ADM_GOTO_INIT = 4'h3,
        ADM_GOTO_HALT = 4'h4
    } ctls_admin_e;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_INIT = 3'b001,
        ST_FIRST = 3'b010,
        ST_ACTIVE = 3'b011,
        ST_IDLE = 3'b100,
        ST_HALT = 3'b101
    } ctls_state_e;
endpackage

// ---- logic/ctls_session.sv ----
`timescale 1ns/1ns
`include "ctls_cfg.svh"
// Overview of operation
// - Go-to-init returns to idle or halt per branch; go-to-halt to halt.
// - After idle or halt, rerun Type A init before forwarding frames.
// - A protocol A or F announcement opens a session, closing any older one.
// - After protocol A announcement, all session frames use Type A alignment.
// - Corrupted or reserved-code frames never stop the running session.
// - Framed receive delay below 500 us plus 11 us per forwarded byte.
// - Chained receive delay measured from previous frame's last I-frame end.
// - Card module acknowledge stalls extend the receive limit.
// - RF acknowledgement starts before related link data finishes; rf_ack_go is only raised in framed mode.
// - Framed transmit delay below 500 us plus 11 us per byte.
// - With acknowledge pending, transmit delay starts at acknowledge end.
// - Waiting extensions and I-frame gaps extend the transmit limit.
// - Each RF block goes whole into exactly one link frame; beats arriving while the link stalls are dropped.
// - Transparent delay runs from last reader pause to link frame end.
// - Oversized RF block is an error; frame is sent with bad CRC.
// - Link transmission may start while RF reception continues.
// - Announce protocol A after each Type A init, nothing during init.
module ctls_session
    import ctls_pkg::*;
#(
    parameter int BASE_CYC = `CTLS_BASE_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_clk,
    input wire logic lnk_rx_valid,
    input wire logic [3:0] lnk_rx_admin,
    input wire logic lnk_rx_crc_ok,
    input wire logic rf_init_done,
    input wire logic rf_sel_halt,
    input wire logic rf_poll_f,
    input wire logic rf_byte_valid,
    input wire logic [7:0] rf_byte,
    input wire logic rf_eof,
    input wire logic rf_ack_req,
    input wire logic rf_ack_wait,
    input wire logic rf_tx_start,
    input wire logic iframe_start,
    input wire logic [7:0] iframe_len,
    input wire logic link_hold,
    output logic rf_reinit,
    output logic rf_ack_go,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [3:0] tx_admin,
    output logic [7:0] tx_byte,
    output logic tx_last,
    output logic tx_bad_crc,
    output logic tx_aligned,
    input wire logic tx_eof_done
);
    // ---------------------------------------------
    // Registers and state
    // ---------------------------------------------
    ctls_state_e st_q;
    logic [2:0] ctrl_q;
    logic [7:0] maxlen_q;
    logic [3:0] viol_q, viol_set, viol_clr;
    logic [19:0] delay_q;
    logic sel_halt_q, sess_open_q, sess_f_q, aligned_q;
    logic in_frame_q, ovf_q;
    logic [7:0] cnt_q, pend_q;
    logic run_q, chain_q, trun_q, tarm_q;
    logic [19:0] el_q, bud_q, tel_q;
    logic [2:0] lclk_s;
    logic [1:0] lv_s, crc_s;
    logic [3:0] adm_s1, adm_s2;
    logic aw_got_q, w_got_q;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic framed, fwd_ok, rx_ev, stall, start_beat, poll_a;
    ctls_admin_e rx_adm;

    function automatic logic [19:0] budget(input logic [7:0] n);
        budget = 20'(BASE_CYC) + 20'(`CTLS_BYTE_CYC) * {12'h0, n};
    endfunction

    assign framed = ctrl_q[`CTLS_CTRL_FRAMED];
    assign fwd_ok = (st_q == ST_FIRST) || (st_q == ST_ACTIVE);
    assign stall = tx_valid && !tx_ready;
    assign start_beat = rf_byte_valid && fwd_ok && !in_frame_q;
    assign poll_a = !(rf_poll_f && ctrl_q[`CTLS_CTRL_FEN]);

    // ---------------------------------------------
    // Link side: clock edge found by sampling
    // ---------------------------------------------
    // Partner holds frame info over a link period, so edge sampling is safe
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lclk_s <= 3'h0;
            lv_s <= 2'h0;
            crc_s <= 2'h0;
            adm_s1 <= 4'h0;
            adm_s2 <= 4'h0;
        end else begin
            lclk_s <= {lclk_s[1:0], link_clk};
            lv_s <= {lv_s[0], lnk_rx_valid};
            crc_s <= {crc_s[0], lnk_rx_crc_ok};
            adm_s1 <= lnk_rx_admin;
            adm_s2 <= adm_s1;
        end
    end
    assign rx_ev = lclk_s[1] && !lclk_s[2] && lv_s[1];
    assign rx_adm = ctls_admin_e'(adm_s2);

    // ---------------------------------------------
    // Session state machine
    // ---------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_q <= ST_OFF;
            sel_halt_q <= 1'b0;
        end else if (!ctrl_q[`CTLS_CTRL_EN]) begin
            st_q <= ST_OFF;
        end else begin
            case (st_q)
                ST_OFF: st_q <= ST_INIT;
                ST_INIT, ST_IDLE, ST_HALT: begin
                    if (rf_init_done) begin
                        st_q <= ST_FIRST;
                        sel_halt_q <= rf_sel_halt;
                    end
                end
                ST_FIRST, ST_ACTIVE: begin
                    // Bad CRC or reserved codes fall through: session kept
                    if (rx_ev && crc_s[1] && sess_open_q) begin
                        if (rx_adm == ADM_GOTO_HALT) begin
                            st_q <= ST_HALT;
                        end else if (rx_adm == ADM_GOTO_INIT) begin
                            st_q <= sel_halt_q ? ST_HALT : ST_IDLE;
                        end else if (st_q == ST_FIRST && rf_eof) begin
                            st_q <= ST_ACTIVE;
                        end
                    end else if (st_q == ST_FIRST && rf_eof &&
                                 in_frame_q) begin
                        st_q <= ST_ACTIVE;
                    end
                end
                default: st_q <= ST_OFF;
            endcase
        end
    end
    // Init is requested again on every return to idle or halt
    assign rf_reinit = (st_q == ST_IDLE) || (st_q == ST_HALT);

    // ---------------------------------------------
    // Session record
    // ---------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn || st_q == ST_OFF) begin
            sess_open_q <= 1'b0;
            sess_f_q <= 1'b0;
            aligned_q <= 1'b0;
        end else if (start_beat && !stall &&
                     (st_q == ST_FIRST || !poll_a)) begin
            sess_open_q <= 1'b1;
            sess_f_q <= !poll_a;
            aligned_q <= poll_a;
        end
    end

    // ---------------------------------------------
    // Frame forwarding, pipelined byte by byte
    // ---------------------------------------------
    // No buffer: a beat arriving while the link stalls is dropped
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tx_valid <= 1'b0;
            tx_admin <= ADM_DATA;
            tx_byte <= 8'h00;
            tx_last <= 1'b0;
            tx_bad_crc <= 1'b0;
            tx_aligned <= 1'b0;
            in_frame_q <= 1'b0;
            ovf_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (!stall) begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            if (rf_eof && in_frame_q) begin
                tx_valid <= 1'b1;
                tx_last <= 1'b1;
                tx_bad_crc <= ovf_q;
                in_frame_q <= 1'b0;
            end else if (rf_byte_valid && (in_frame_q || fwd_ok)) begin
                if (!in_frame_q) begin
                    tx_admin <= (st_q == ST_FIRST && poll_a) ? ADM_PROTO_A :
                                (poll_a ? ADM_DATA : ADM_PROTO_F);
                    tx_aligned <= poll_a && (st_q == ST_FIRST ||
                                  aligned_q);
                    ovf_q <= 1'b0;
                    cnt_q <= 8'h01;
                    in_frame_q <= 1'b1;
                    tx_bad_crc <= 1'b0;
                    tx_valid <= 1'b1;
                    tx_byte <= rf_byte;
                end else if (cnt_q >= maxlen_q) begin
                    ovf_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                    tx_valid <= 1'b1;
                    tx_byte <= rf_byte;
                end
            end
        end
    end
    assign rf_ack_go = rf_ack_req && framed;

    // ---------------------------------------------
    // Receive delay timer
    // ---------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            run_q <= 1'b0;
            chain_q <= 1'b0;
            el_q <= 20'h0;
            bud_q <= 20'h0;
            pend_q <= 8'h00;
            delay_q <= 20'h0;
        end else begin
            if (run_q && !link_hold && el_q != 20'hfffff) begin
                el_q <= el_q + 20'h1;
            end
            if (run_q && tx_eof_done) begin
                delay_q <= el_q;
                if (chain_q) begin
                    el_q <= 20'h0;
                    bud_q <= budget(pend_q);
                    chain_q <= 1'b0;
                end else begin
                    run_q <= 1'b0;
                end
            end else if (rf_eof && in_frame_q) begin
                if (run_q) begin
                    chain_q <= 1'b1;
                    pend_q <= cnt_q;
                end else begin
                    run_q <= 1'b1;
                    el_q <= 20'h0;
                    bud_q <= budget(cnt_q);
                end
            end
        end
    end

    // ---------------------------------------------
    // Transmit delay timer
    // ---------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            trun_q <= 1'b0;
            tarm_q <= 1'b0;
            tel_q <= 20'h0;
        end else begin
            if (trun_q && !link_hold && tel_q != 20'hfffff) begin
                tel_q <= tel_q + 20'h1;
            end
            if (rf_tx_start) begin
                trun_q <= 1'b0;
                tarm_q <= 1'b0;
            end else if (iframe_start && rf_ack_wait) begin
                tarm_q <= 1'b1;
            end else if ((iframe_start || tarm_q) && !rf_ack_wait) begin
                trun_q <= 1'b1;
                tarm_q <= 1'b0;
                tel_q <= 20'h0;
            end
        end
    end

    // ---------------------------------------------
    // Violation flags, set wins over clear
    // ---------------------------------------------
    always_comb begin
        viol_set = 4'h0;
        viol_set[`CTLS_V_RXLATE] = framed && run_q && tx_eof_done &&
                                   el_q >= bud_q;
        viol_set[`CTLS_V_TXLATE] = framed && trun_q && rf_tx_start &&
                                   tel_q >= budget(iframe_len);
        viol_set[`CTLS_V_OVF] = rf_byte_valid && in_frame_q && !stall &&
                                cnt_q >= maxlen_q;
        viol_set[`CTLS_V_DROP] = stall && (rf_byte_valid || rf_eof);
    end

    // ---------------------------------------------
    // AXI4-Lite slave
    // ---------------------------------------------
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready = !w_got_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign viol_clr = (aw_got_q && w_got_q && aw_q == `CTLS_A_VIOL &&
                       w_q[31] == 1'b0) ? w_q[3:0] : 4'h0;

    // Address and data may arrive in either order
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            ctrl_q <= `CTLS_CTRL_RST;
            maxlen_q <= `CTLS_MAXLEN_RST;
            viol_q <= 4'h0;
        end else begin
            viol_q <= (viol_q & ~viol_clr) | viol_set;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                w_q <= {1'b0, s_axi_wdata[30:0] &
                        {{27{1'b0}}, {4{s_axi_wstrb[0]}}}};
                w_q[7:4] <= s_axi_wstrb[0] ? s_axi_wdata[7:4] : 4'h0;
            end
            if (aw_got_q && w_got_q) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (aw_q)
                    `CTLS_A_CTRL: ctrl_q <= w_q[2:0];
                    `CTLS_A_MAXLEN: maxlen_q <= w_q[7:0];
                    `CTLS_A_VIOL, `CTLS_A_STAT, `CTLS_A_DELAY: ;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read data is registered; unmapped reads answer SLVERR with zero
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `CTLS_A_CTRL: s_axi_rdata <= {29'h0, ctrl_q};
                `CTLS_A_STAT: s_axi_rdata <= {24'h0, sel_halt_q,
                    aligned_q, sess_f_q, sess_open_q, 1'b0, st_q};
                `CTLS_A_VIOL: s_axi_rdata <= {28'h0, viol_q};
                `CTLS_A_MAXLEN: s_axi_rdata <= {24'h0, maxlen_q};
                `CTLS_A_DELAY: s_axi_rdata <= {12'h0, delay_q};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    AST_GOTO_HALT: assert property (
        ctrl_q[0] && st_q == ST_ACTIVE && rx_ev && crc_s[1] &&
        rx_adm == ADM_GOTO_HALT |=> st_q == ST_HALT)
        else $error("go-to-halt did not reach halt");
    AST_GOTO_INIT: assert property (
        ctrl_q[0] && st_q == ST_ACTIVE && rx_ev && crc_s[1] &&
        rx_adm == ADM_GOTO_INIT |=>
        st_q == (sel_halt_q ? ST_HALT : ST_IDLE))
        else $error("go-to-init took wrong branch");
    AST_REINIT: assert property (
        st_q == ST_HALT && !rf_init_done && ctrl_q[0] |=>
        rf_reinit && !fwd_ok)
        else $error("frames allowed before reinit");
    AST_NO_INIT_TX: assert property (
        st_q == ST_INIT && !tx_valid |=> !tx_valid)
        else $error("frame sent during init");
    AST_ANNOUNCE_A: assert property (
        st_q == ST_FIRST && start_beat && poll_a && !stall && !rf_eof |=>
        tx_valid && tx_admin == ADM_PROTO_A && tx_aligned ##0 sess_open_q)
        else $error("missing protocol A announcement");
    AST_KEEP_SESSION: assert property (
        ctrl_q[0] && st_q == ST_ACTIVE && rx_ev && !crc_s[1] |=>
        st_q == ST_ACTIVE && $stable(sess_open_q))
        else $error("corrupt frame dropped session");
    AST_OVF_BAD: assert property (
        in_frame_q && ovf_q && rf_eof && !stall |=> tx_last && tx_bad_crc)
        else $error("oversize frame not marked bad");
    AST_RX_LATE: assert property (
        framed && run_q && tx_eof_done && el_q >= bud_q |=>
        viol_q[`CTLS_V_RXLATE])
        else $error("late receive not flagged");
    AST_ACK: assert property (
        framed && rf_ack_req |-> rf_ack_go)
        else $error("ack not started");
    CV_HALT: cover property (st_q == ST_ACTIVE ##1 st_q == ST_HALT);
    CV_FRAME: cover property (tx_valid && tx_last && tx_ready);
    CV_CHAIN: cover property (chain_q && tx_eof_done);
endmodule

// ---- test/contactless_transparent_link_session_tb_top.sv ----
`timescale 1ns/1ns
`include "ctls_cfg.svh"
// ---------------------------------------------
// Session block bench
// ---------------------------------------------
module contactless_transparent_link_session_tb_top import ctls_pkg::*;;
    localparam int BASE = 50;
    logic sys_clk = 1'b0, rstn = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, s_axi_awvalid;
    logic s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic link_clk, lnk_rx_valid, lnk_rx_crc_ok, tx_ready, tx_eof_done;
    logic tx_valid, tx_last, tx_bad_crc, tx_aligned, rf_reinit, rf_ack_go;
    logic rf_init_done, rf_sel_halt, rf_poll_f, rf_byte_valid, rf_eof;
    logic rf_ack_req, rf_ack_wait, rf_tx_start, iframe_start, link_hold;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
    logic [3:0] lnk_rx_admin, tx_admin, s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rf_byte, iframe_len, tx_byte;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [9:0] eof_delay;
    logic [14:0] beat;
    logic [14:0] exp_q[$];
    int errors = 0, checks = 0, cycles = 0, seed, maxlen;

    ctls_session #(.BASE_CYC(BASE)) u_dut (.sys_clk, .rstn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk,
        .lnk_rx_valid, .lnk_rx_admin, .lnk_rx_crc_ok, .rf_init_done,
        .rf_sel_halt, .rf_poll_f, .rf_byte_valid, .rf_byte, .rf_eof,
        .rf_ack_req, .rf_ack_wait, .rf_tx_start, .iframe_start, .iframe_len,
        .link_hold, .rf_reinit, .rf_ack_go, .tx_valid, .tx_ready, .tx_admin,
        .tx_byte, .tx_last, .tx_bad_crc, .tx_aligned, .tx_eof_done);
    ctls_card_model u_card (.sys_clk, .rstn, .eof_delay, .link_clk,
        .lnk_rx_valid, .lnk_rx_admin, .lnk_rx_crc_ok, .tx_valid, .tx_ready,
        .tx_admin, .tx_last, .tx_bad_crc, .tx_eof_done);

    always #50 sys_clk = ~sys_clk;

    task automatic stop_test();
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // Hang guard, well above the length of the sequence
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            stop_test();
        end
    end

    // Accepted beats are matched to the oldest note; closing byte is junk
    assign beat = {tx_admin, tx_last ? 8'h00 : tx_byte, tx_last, tx_bad_crc,
                   tx_aligned};
    always @(posedge sys_clk) begin
        if (rstn && tx_valid && tx_ready) begin
            if (exp_q.size() == 0) chk({17'h0, beat}, 32'hffffffff);
            else chk({17'h0, beat}, {17'h0, exp_q.pop_front()});
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
    endtask

    task automatic st(input logic [2:0] s);
        rd(`CTLS_A_STAT);
        chk({29'h0, rd_d[2:0]}, {29'h0, s});
    endtask

    task automatic rf_init(input logic h);
        @(posedge sys_clk);
        rf_sel_halt <= h;
        rf_init_done <= 1'b1;
        @(posedge sys_clk);
        rf_init_done <= 1'b0;
    endtask

    // RF block with random bytes four cycles apart, noting expected beats
    task automatic rf_frame(input int n, input logic [3:0] adm,
                            input logic al, input logic fwd);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            rf_byte <= 8'($random(seed));
            rf_byte_valid <= 1'b1;
            @(posedge sys_clk);
            rf_byte_valid <= 1'b0;
            if (fwd && i < maxlen) exp_q.push_back({adm, rf_byte, 2'h0, al});
            repeat (2) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        rf_eof <= 1'b1;
        @(posedge sys_clk);
        rf_eof <= 1'b0;
        if (fwd) exp_q.push_back({adm, 8'h00, 1'b1, n > maxlen, al});
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic tx_gap(input int g);
        @(posedge sys_clk);
        iframe_len <= 8'h01;
        iframe_start <= 1'b1;
        @(posedge sys_clk);
        iframe_start <= 1'b0;
        repeat (g) @(posedge sys_clk);
        rf_tx_start <= 1'b1;
        @(posedge sys_clk);
        rf_tx_start <= 1'b0;
        rd(`CTLS_A_VIOL);
    endtask

    // Main sequence; ack wait, hold and byte strobes stay fixed
    initial begin
        seed = 58676;
        maxlen = 29;
        eof_delay = 10'h005;
        s_axi_wstrb = 4'hf;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
         s_axi_araddr, s_axi_arvalid, s_axi_rready, rf_init_done, rf_sel_halt,
         rf_poll_f, rf_byte_valid, rf_byte, rf_eof, rf_ack_req, rf_ack_wait,
         rf_tx_start, iframe_start, iframe_len, link_hold} = '0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(`CTLS_A_CTRL);
        chk(rd_d, 32'h1);
        rd(`CTLS_A_MAXLEN);
        chk(rd_d, 32'h1d);
        rd(8'h40);
        chk({rd_d[29:0], rd_r}, 32'h2);
        wr(8'h40, 32'h0, 2'h2);
        st(3'h1);
        rf_frame(2, ADM_DATA, 1'b0, 1'b0);
        rf_init(1'b0);
        rf_frame(3, ADM_PROTO_A, 1'b1, 1'b1);
        rd(`CTLS_A_STAT);
        chk(rd_d, 32'h53);
        rf_frame(1, ADM_DATA, 1'b1, 1'b1);
        u_card.send(ADM_GOTO_HALT, 1'b0);
        u_card.send(4'h7, 1'b1);
        st(3'h3);
        u_card.send(ADM_GOTO_INIT, 1'b1);
        st(3'h4);
        chk({31'h0, rf_reinit}, 32'h1);
        rf_frame(2, ADM_DATA, 1'b1, 1'b0);
        rf_init(1'b1);
        rf_frame(1, ADM_PROTO_A, 1'b1, 1'b1);
        u_card.send(ADM_GOTO_INIT, 1'b1);
        st(3'h5);
        rf_init(1'b0);
        rf_frame(1, ADM_PROTO_A, 1'b1, 1'b1);
        u_card.send(ADM_GOTO_HALT, 1'b1);
        st(3'h5);
        wr(`CTLS_A_MAXLEN, 32'h2, 2'h0);
        maxlen = 2;
        rf_init(1'b0);
        rf_frame(1, ADM_PROTO_A, 1'b1, 1'b1);
        rf_frame(4, ADM_DATA, 1'b1, 1'b1);
        rd(`CTLS_A_VIOL);
        chk(rd_d & 32'h4, 32'h4);
        wr(`CTLS_A_VIOL, 32'hf, 2'h0);
        maxlen = 29;
        wr(`CTLS_A_MAXLEN, 32'h1d, 2'h0);
        wr(`CTLS_A_CTRL, 32'h5, 2'h0);
        u_card.send(ADM_GOTO_INIT, 1'b1);
        rf_init(1'b0);
        rf_poll_f <= 1'b1;
        rf_frame(2, ADM_PROTO_F, 1'b0, 1'b1);
        rf_poll_f <= 1'b0;
        rf_frame(1, ADM_DATA, 1'b0, 1'b1);
        rd(`CTLS_A_STAT);
        chk(rd_d & 32'h77, 32'h33);
        rf_ack_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, rf_ack_go}, 32'h0);
        wr(`CTLS_A_CTRL, 32'h3, 2'h0);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, rf_ack_go}, 32'h1);
        rf_ack_req <= 1'b0;
        rf_frame(1, ADM_DATA, 1'b0, 1'b1);
        repeat (20) @(posedge sys_clk);
        rd(`CTLS_A_VIOL);
        chk(rd_d, 32'h0);
        eof_delay <= 10'h12c;
        rf_frame(1, ADM_DATA, 1'b0, 1'b1);
        repeat (320) @(posedge sys_clk);
        rd(`CTLS_A_VIOL);
        chk(rd_d & 32'h1, 32'h1);
        wr(`CTLS_A_VIOL, 32'hf, 2'h0);
        tx_gap(BASE + 110 - 60);
        chk(rd_d, 32'h0);
        tx_gap(BASE + 110 + 40);
        chk(rd_d & 32'h2, 32'h2);
        stop_test();
    end
endmodule

// ---- test/ctls_card_model.sv ----
`timescale 1ns/1ns
// ---------------------------------------------
// Card module model at the far end of the link
// ---------------------------------------------
module ctls_card_model
    import ctls_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [9:0] eof_delay,
    output logic link_clk,
    output logic lnk_rx_valid,
    output logic [3:0] lnk_rx_admin,
    output logic lnk_rx_crc_ok,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [3:0] tx_admin,
    input wire logic tx_last,
    input wire logic tx_bad_crc,
    output logic tx_eof_done
);
    logic open_q;
    logic [1:0] rdy_q;
    int wait_q;

    // Link idle: clock stands still between frames
    initial begin
        link_clk = 1'b0;
        lnk_rx_valid = 1'b0;
        lnk_rx_admin = 4'h0;
        lnk_rx_crc_ok = 1'b0;
    end

    // Accept three beats in four so the sender sees stalls
    always_ff @(posedge sys_clk) begin
        if (!rstn) rdy_q <= 2'h0;
        else rdy_q <= rdy_q + 2'h1;
    end
    assign tx_ready = (rdy_q != 2'h3);

    // An announcement opens a fresh session; bad CRC beats are dropped
    always_ff @(posedge sys_clk) begin
        if (!rstn) open_q <= 1'b0;
        else if (tx_valid && tx_ready && !tx_bad_crc &&
                 (tx_admin == ADM_PROTO_A || tx_admin == ADM_PROTO_F))
            open_q <= 1'b1;
    end

    // End of frame reported a settable time after the closing beat
    always_ff @(posedge sys_clk) begin
        tx_eof_done <= 1'b0;
        if (!rstn) wait_q <= 0;
        else if (tx_valid && tx_ready && tx_last) wait_q <= int'(eof_delay);
        else if (wait_q == 1) begin
            wait_q <= 0;
            tx_eof_done <= 1'b1;
        end else if (wait_q > 1) wait_q <= wait_q - 1;
    end

    // One link frame; the clock edges are offset so they fall between sys_clk edges
    task automatic send(input logic [3:0] adm, input logic ok);
        if (!open_q) return;
        @(posedge sys_clk);
        lnk_rx_valid <= 1'b1;
        lnk_rx_admin <= adm;
        lnk_rx_crc_ok <= ok;
        #437 link_clk = 1'b1;
        #400 link_clk = 1'b0;
        @(posedge sys_clk);
        lnk_rx_valid <= 1'b0;
        lnk_rx_admin <= ~adm;
        lnk_rx_crc_ok <= ~ok;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule
